// [src/timer_pkg.sv]
package timer_pkg;
  // ==================================================
  // Register byte addresses (one aligned word each)
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CNT_HI = 8'h04;
  localparam logic [7:0] ADDR_CNT_LO = 8'h08;
  localparam logic [7:0] ADDR_MOD_HI = 8'h0c;
  localparam logic [7:0] ADDR_MOD_LO = 8'h10;
  localparam logic [7:0] ADDR_CHAN_BASE = 8'h14;
  localparam logic [7:0] CHAN_STRIDE = 8'h0c;
  localparam logic [7:0] CHAN_SC_OFS = 8'h00;
  localparam logic [7:0] CHAN_HI_OFS = 8'h04;
  localparam logic [7:0] CHAN_LO_OFS = 8'h08;
  // ==================================================
  // Status and control field positions
  localparam int FLAG_BIT = 7;
  localparam int OVERFLOW_IRQ_ENABLE_BIT = 6;
  localparam int HALT_BIT = 5;
  localparam int TRST_BIT = 4;
  localparam int BUF_BIT = 5;
  // ==================================================
  // Reset values and codes
  localparam logic HALT_RESET = 1'b1;
  localparam logic [2:0] PRESCALE_RESET = 3'h0;
  localparam logic [2:0] PRESCALE_EXT = 3'h7;
  localparam logic [15:0] MODULO_RESET = 16'hffff;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [7:0] CHAN_CTL_RESET = 8'h00;
  localparam logic [31:0] HRDATA_RESET = 32'h00000000;
  // ==================================================
  // Types
  typedef struct packed {
    logic channel_event_flag;
    logic channel_irq_enable;
    logic buffered_mode_select;
    logic compare_mode_select;
    logic edge_level_sel_hi;
    logic edge_level_sel_lo;
    logic toggle_at_wrap;
    logic full_duty_force;
  } chan_ctl_type;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
  } bus_req_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DATA = 2'b10
  } bus_state_type;
endpackage

// [src/first_timer_module.sv]
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Each channel capture or compare; buffering on 0,2
// - Prescale code 111 counts external clock edges
// - Codes 000-110 divide bus clock 1..64
// - Overflow flag sets when counter hits modulo
// - Overflow clears by flagged read, zero write
// - Overflow between read and write keeps flag
// - Overflow enable gates overflow interrupt request
// - Halt bit stops counter; reset sets it
// - No captures while counter halted
// - Reset bit clears counter, prescaler; reads zero
// - Halt with reset bit leaves counter zero
// - High read latches low byte until read
// - Counter wraps to zero after modulo value
// - Modulo high write holds overflow until low
// - Channel flag on capture edge or match
// - Channel flag clears by flagged read, zero write
// - Channel enable gates channel interrupt request
// - Buffered bit on even channels frees partner
// - Edge bits pick capture edge, compare action
// - Edge bits 00 free pin, preset level
// - Toggle on wrap for compare channels only
// - Overflow toggle beats same-time compare action
// - Full duty forces pulse level next cycle
// - High byte access holds compare or capture
module first_timer_module
  import timer_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output var logic hreadyout,
  output var logic hresp,
  output var logic [31:0] hrdata,
  input wire logic [3:0] channel_pin_in,
  output var logic [3:0] channel_pin_out,
  output var logic [3:0] channel_pin_oe,
  input wire logic external_count_clock_pin,
  output var logic timer_irq
);
  import timer_pkg::*;

  function automatic logic chan_hit(input logic [7:0] a, input int i, input logic [7:0] ofs);
    return a == 8'(int'(ADDR_CHAN_BASE) + int'(CHAN_STRIDE) * i + int'(ofs));
  endfunction

  function automatic logic is_capture(input chan_ctl_type c);
    return !c.buffered_mode_select && !c.compare_mode_select &&
           (c.edge_level_sel_hi || c.edge_level_sel_lo);
  endfunction

  function automatic logic is_compare(input chan_ctl_type c);
    return c.buffered_mode_select || c.compare_mode_select;
  endfunction

  // ==================================================
  // Bus slave
  bus_state_type bus_state;
  bus_req_type req;
  logic wr_now;
  logic rd_now;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;

  assign wr_now = (bus_state == BUS_DATA) && req.write;
  assign rd_now = (bus_state == BUS_DATA) && !req.write;
  assign wbyte = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= BUS_IDLE;
      req <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= HRDATA_RESET;
    end else begin
      unique case (bus_state)
        BUS_IDLE: begin
          if (hsel && htrans[1] && hready) begin
            req.addr <= haddr[7:0];
            req.write <= hwrite;
            hreadyout <= 1'b0;
            bus_state <= BUS_DATA;
          end
        end
        BUS_DATA: begin
          if (!req.write) begin
            hrdata <= {24'h000000, rd_byte};
          end
          hreadyout <= 1'b1;
          bus_state <= BUS_IDLE;
        end
      endcase
    end
  end

  // ==================================================
  // Counter, prescaler, modulo
  logic overflow_flag;
  logic ovf_irq_en;
  logic counter_halt;
  logic [2:0] prescale_select;
  logic ovf_armed;
  logic [15:0] cnt;
  logic [5:0] presc;
  logic [5:0] presc_mask;
  logic [15:0] modulo;
  logic mod_hold;
  logic [7:0] cnt_buf;
  logic cnt_latched;
  logic ext_s1, ext_s2, ext_prev;
  logic trst_now;
  logic presc_tick;
  logic tick;
  logic ovf_evt;
  logic ovf_set;

  assign trst_now = wr_now && (req.addr == ADDR_STATUS) && wbyte[TRST_BIT];
  assign presc_mask = 6'((7'h01 << prescale_select) - 7'h01);
  assign presc_tick = (presc & presc_mask) == presc_mask;
  assign tick = !counter_halt && !trst_now &&
                ((prescale_select == PRESCALE_EXT) ? (ext_s2 && !ext_prev)
                                                   : presc_tick);
  assign ovf_evt = tick && (cnt == modulo);
  assign ovf_set = ovf_evt && !mod_hold;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_s1 <= external_count_clock_pin;
      ext_s2 <= ext_s1;
      ext_prev <= ext_s2;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= CNT_RESET;
      presc <= 6'h00;
    end else if (trst_now) begin
      cnt <= CNT_RESET;
      presc <= 6'h00;
    end else begin
      if (!counter_halt) begin
        presc <= presc + 6'h01;
      end
      if (tick) begin
        cnt <= (cnt == modulo) ? CNT_RESET : cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_latched <= 1'b0;
      cnt_buf <= 8'h00;
    end else if (trst_now) begin
      cnt_latched <= 1'b0;
      cnt_buf <= 8'h00;
    end else if (rd_now && req.addr == ADDR_CNT_HI && !cnt_latched) begin
      cnt_latched <= 1'b1;
      cnt_buf <= cnt[7:0];
    end else if (rd_now && req.addr == ADDR_CNT_LO) begin
      cnt_latched <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      modulo <= MODULO_RESET;
      mod_hold <= 1'b0;
    end else if (wr_now && req.addr == ADDR_MOD_HI) begin
      modulo[15:8] <= wbyte;
      mod_hold <= 1'b1;
    end else if (wr_now && req.addr == ADDR_MOD_LO) begin
      modulo[7:0] <= wbyte;
      mod_hold <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_irq_en <= 1'b0;
      counter_halt <= HALT_RESET;
      prescale_select <= PRESCALE_RESET;
    end else if (wr_now && req.addr == ADDR_STATUS) begin
      ovf_irq_en <= wbyte[OVERFLOW_IRQ_ENABLE_BIT];
      counter_halt <= wbyte[HALT_BIT];
      prescale_select <= wbyte[2:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_flag <= 1'b0;
      ovf_armed <= 1'b0;
    end else if (ovf_set) begin
      overflow_flag <= 1'b1;
      ovf_armed <= 1'b0;
    end else if (wr_now && req.addr == ADDR_STATUS) begin
      if (ovf_armed && !wbyte[FLAG_BIT]) begin
        overflow_flag <= 1'b0;
      end
      ovf_armed <= 1'b0;
    end else if (rd_now && req.addr == ADDR_STATUS && overflow_flag) begin
      ovf_armed <= 1'b1;
    end
  end

  // ==================================================
  // Channels
  chan_ctl_type ctl [4];
  logic [15:0] chv [4];
  logic [15:0] cmpval [4];
  logic [3:0] ch_armed;
  logic [3:0] cmp_hold;
  logic [3:0] cap_hold;
  logic [3:0] pin_s1, pin_s2, pin_prev;
  logic [1:0] active_odd;
  logic [1:0] pending_odd;
  logic [3:0] ignored;
  logic [3:0] cmp_evt;
  logic [3:0] cap_evt;

  assign ignored = {ctl[2].buffered_mode_select, 1'b0, ctl[0].buffered_mode_select, 1'b0};

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cmpval[i] = (!i[0] && ctl[i].buffered_mode_select && active_odd[i >> 1]) ?
                  chv[i | 1] : chv[i];
      cmp_evt[i] = is_compare(ctl[i]) && !ignored[i] && tick &&
                   (cnt == cmpval[i]) && !cmp_hold[i];
      cap_evt[i] = is_capture(ctl[i]) && !ignored[i] && !counter_halt &&
                   !cap_hold[i] &&
                   ((ctl[i].edge_level_sel_lo && pin_s2[i] && !pin_prev[i]) ||
                    (ctl[i].edge_level_sel_hi && !pin_s2[i] && pin_prev[i]));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_prev <= 4'h0;
    end else begin
      pin_s1 <= channel_pin_in;
      pin_s2 <= pin_s1;
      pin_prev <= pin_s2;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 4; i++) begin
        ctl[i] <= CHAN_CTL_RESET;
      end
      ch_armed <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_now && chan_hit(req.addr, i, CHAN_SC_OFS)) begin
          ctl[i].channel_irq_enable <= wbyte[6];
          ctl[i].buffered_mode_select <= wbyte[BUF_BIT] && !i[0];
          ctl[i].compare_mode_select <= wbyte[4];
          ctl[i].edge_level_sel_hi <= wbyte[3];
          ctl[i].edge_level_sel_lo <= wbyte[2];
          ctl[i].toggle_at_wrap <= wbyte[1];
          ctl[i].full_duty_force <= wbyte[0];
        end
        if (cmp_evt[i] || cap_evt[i]) begin
          ctl[i].channel_event_flag <= 1'b1;
          ch_armed[i] <= 1'b0;
        end else if (wr_now && chan_hit(req.addr, i, CHAN_SC_OFS)) begin
          if (ch_armed[i] && !wbyte[FLAG_BIT]) begin
            ctl[i].channel_event_flag <= 1'b0;
          end
          ch_armed[i] <= 1'b0;
        end else if (rd_now && chan_hit(req.addr, i, CHAN_SC_OFS) &&
                     ctl[i].channel_event_flag) begin
          ch_armed[i] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 4; i++) begin
        chv[i] <= 16'h0000;
      end
      cmp_hold <= 4'h0;
      cap_hold <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (cap_evt[i]) begin
          chv[i] <= cnt;
        end else if (wr_now && chan_hit(req.addr, i, CHAN_HI_OFS)) begin
          chv[i][15:8] <= wbyte;
        end else if (wr_now && chan_hit(req.addr, i, CHAN_LO_OFS)) begin
          chv[i][7:0] <= wbyte;
        end
        if (wr_now && chan_hit(req.addr, i, CHAN_HI_OFS) && is_compare(ctl[i])) begin
          cmp_hold[i] <= 1'b1;
        end else if (wr_now && chan_hit(req.addr, i, CHAN_LO_OFS)) begin
          cmp_hold[i] <= 1'b0;
        end
        if (rd_now && chan_hit(req.addr, i, CHAN_HI_OFS) && is_capture(ctl[i])) begin
          cap_hold[i] <= 1'b1;
        end else if (rd_now && chan_hit(req.addr, i, CHAN_LO_OFS)) begin
          cap_hold[i] <= 1'b0;
        end
      end
    end
  end

  // Buffered pairs: last written register set takes over at wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_odd <= 2'b00;
      pending_odd <= 2'b00;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (!ctl[2 * p].buffered_mode_select) begin
          active_odd[p] <= 1'b0;
          pending_odd[p] <= 1'b0;
        end else begin
          if (wr_now && (chan_hit(req.addr, 2 * p + 1, CHAN_HI_OFS) ||
                         chan_hit(req.addr, 2 * p + 1, CHAN_LO_OFS))) begin
            pending_odd[p] <= 1'b1;
          end else if (wr_now && (chan_hit(req.addr, 2 * p, CHAN_HI_OFS) ||
                                  chan_hit(req.addr, 2 * p, CHAN_LO_OFS))) begin
            pending_odd[p] <= 1'b0;
          end
          if (ovf_evt) begin
            active_odd[p] <= pending_odd[p];
          end
        end
      end
    end
  end

  // Pin level and drive
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_pin_out <= 4'hf;
      channel_pin_oe <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        channel_pin_oe[i] <= is_compare(ctl[i]) && !ignored[i] &&
                             (ctl[i].edge_level_sel_hi || ctl[i].edge_level_sel_lo);
        if (!ctl[i].edge_level_sel_hi && !ctl[i].edge_level_sel_lo) begin
          channel_pin_out[i] <= !ctl[i].compare_mode_select;
        end else if (is_compare(ctl[i]) && !ignored[i]) begin
          if (ctl[i].toggle_at_wrap && ctl[i].full_duty_force) begin
            channel_pin_out[i] <= !ctl[i].edge_level_sel_lo;
          end else if (ctl[i].toggle_at_wrap && ovf_evt) begin
            channel_pin_out[i] <= !channel_pin_out[i];
          end else if (cmp_evt[i]) begin
            unique case ({ctl[i].edge_level_sel_hi, ctl[i].edge_level_sel_lo})
              2'b01: channel_pin_out[i] <= !channel_pin_out[i];
              2'b10: channel_pin_out[i] <= 1'b0;
              2'b11: channel_pin_out[i] <= 1'b1;
              2'b00: channel_pin_out[i] <= channel_pin_out[i];
            endcase
          end
        end
      end
    end
  end

  // ==================================================
  // Interrupt request and read mux
  logic [3:0] ch_req;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ch_req[i] = ctl[i].channel_event_flag && ctl[i].channel_irq_enable;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= (overflow_flag && ovf_irq_en && !mod_hold) || (|ch_req);
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (req.addr == ADDR_STATUS) begin
      rd_byte = {overflow_flag, ovf_irq_en, counter_halt, 2'b00, prescale_select};
    end else if (req.addr == ADDR_CNT_HI) begin
      rd_byte = cnt[15:8];
    end else if (req.addr == ADDR_CNT_LO) begin
      rd_byte = cnt_latched ? cnt_buf : cnt[7:0];
    end else if (req.addr == ADDR_MOD_HI) begin
      rd_byte = modulo[15:8];
    end else if (req.addr == ADDR_MOD_LO) begin
      rd_byte = modulo[7:0];
    end
    for (int i = 0; i < 4; i++) begin
      if (chan_hit(req.addr, i, CHAN_SC_OFS)) begin
        rd_byte = ctl[i];
      end else if (chan_hit(req.addr, i, CHAN_HI_OFS)) begin
        rd_byte = chv[i][15:8];
      end else if (chan_hit(req.addr, i, CHAN_LO_OFS)) begin
        rd_byte = chv[i][7:0];
      end
    end
  end

  // ==================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_hi_latch;
    rd_now && req.addr == ADDR_CNT_HI && !cnt_latched;
  endsequence
  sequence s_latched_kept;
    cnt_latched && cnt_buf == $past(cnt[7:0], 1);
  endsequence

  property p_ovf_set;
    tick && cnt == modulo && !mod_hold |=> overflow_flag;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

  property p_wrap;
    tick && cnt == modulo |=> cnt == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_halt;
    counter_halt && !trst_now |=> $stable(cnt);
  endproperty
  a_halt: assert property (p_halt) else $error("counter moved while halted");

  property p_trst;
    trst_now |=> cnt == 16'h0000 && presc == 6'h00;
  endproperty
  a_trst: assert property (p_trst) else $error("reset bit did not clear counter");

  property p_one_no_clear;
    wr_now && req.addr == ADDR_STATUS && wbyte[FLAG_BIT] && overflow_flag |=> overflow_flag;
  endproperty
  a_one_no_clear: assert property (p_one_no_clear) else $error("one write cleared flag");

  property p_irq;
    overflow_flag && ovf_irq_en && !mod_hold |=> timer_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("overflow request missing");

  property p_ext_clk;
    prescale_select == PRESCALE_EXT && !(ext_s2 && !ext_prev) && !trst_now |=> $stable(cnt);
  endproperty
  a_ext_clk: assert property (p_ext_clk) else $error("counter moved without edge");

  property p_div1;
    prescale_select == 3'h0 && !counter_halt && !trst_now && cnt != modulo
      |=> cnt == $past(cnt) + 16'h0001;
  endproperty
  a_div1: assert property (p_div1) else $error("divide by one missed a count");

  property p_latch;
    s_hi_latch |=> s_latched_kept;
  endproperty
  a_latch: assert property (p_latch) else $error("low byte not latched");

  // Captured values must not move while halted, whatever the pins do
  property p_cap_halt;
    counter_halt && !wr_now |=> $stable(chv[0]) && $stable(chv[1]) &&
                                $stable(chv[2]) && $stable(chv[3]);
  endproperty
  a_cap_halt: assert property (p_cap_halt) else $error("capture while halted");

  // Wrap toggle on channel 0 must happen even when a compare falls on it
  property p_wrap_wins;
    is_compare(ctl[0]) && !ignored[0] && ctl[0].toggle_at_wrap && !ctl[0].full_duty_force &&
      (ctl[0].edge_level_sel_hi || ctl[0].edge_level_sel_lo) && ovf_evt
      |=> channel_pin_out[0] != $past(channel_pin_out[0]);
  endproperty
  a_wrap_wins: assert property (p_wrap_wins) else $error("wrap toggle lost");
endmodule
`default_nettype wire

// [tb/pin_partner.sv]
`timescale 1ns/1ns
`default_nettype none
module pin_partner (
  input wire logic [3:0] level_req,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  output var logic [3:0] pin_wire,
  output var logic ext_clk
);
  // ==================================================
  // Pin levels seen by the timer
  always_comb pin_wire = (pin_oe & pin_out) | (~pin_oe & level_req);
  initial ext_clk = 1'b0;
  // ==================================================
  // Count clock bursts, idle low, below half the bus rate
  task automatic pulses(input int k);
    repeat (k) begin
      #57 ext_clk = 1'b1;
      #61 ext_clk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [tb/first_timer_module_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module first_timer_module_bench;
  import timer_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] level_req = 4'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [3:0] pin_out;
  logic [3:0] pin_oe;
  logic [3:0] pin_wire;
  logic ext_clk;
  logic timer_irq;
  logic [31:0] rd;
  int miscompares = 0;
  int samples_checked = 0;
  int v;
  int k;
  int hi;
  // Reset model: address, expected value
  int rst_map[$] = '{8'h00, 8'h20, 8'h04, 8'h00, 8'h08, 8'h00, 8'h0c, 8'hff, 8'h10, 8'hff,
                     8'h14, 8'h00, 8'h20, 8'h00, 8'h2c, 8'h00, 8'h38, 8'h00, 8'hfc, 8'h00};

  always #20 hclk = ~hclk;

  first_timer_module dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .channel_pin_in(pin_wire),
    .channel_pin_out(pin_out), .channel_pin_oe(pin_oe), .external_count_clock_pin(ext_clk),
    .timer_irq(timer_irq));

  pin_partner partner (.level_req(level_req), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_wire(pin_wire), .ext_clk(ext_clk));

  // ==================================================
  // Reporting
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ==================================================
  // Bus master
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic edge_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (n >= 40) begin
      miscompares++;
      conclude();
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    edge_ready();
    htrans <= 2'h0;
    hwdata <= d;
    edge_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rd, e);
    check(hresp, 32'h0);
  endtask

  task automatic wait_irq(input int bound);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (timer_irq !== 1'b1 && n < bound);
    if (n >= bound) begin
      miscompares++;
      conclude();
    end
  endtask

  initial begin
    #4000000;
    miscompares++;
    conclude();
  end

  // ==================================================
  // Scenarios
  initial begin
    v = $urandom(32'h1927);
    cyc(12);
    hresetn <= 1'b1;
    for (int i = 0; i < rst_map.size(); i += 2) rdchk(rst_map[i][7:0], rst_map[i + 1]);
    wr(ADDR_MOD_HI, 32'h0);
    wr(ADDR_MOD_LO, 32'h1);
    wr(ADDR_STATUS, 32'h36);
    wr(ADDR_STATUS, 32'h46);
    wait_irq(400);
    rdchk(ADDR_STATUS, 32'hc6);
    wr(ADDR_STATUS, 32'h46);
    rdchk(ADDR_STATUS, 32'h46);
    check(timer_irq, 32'h0);
    wr(ADDR_STATUS, 32'hc6);
    rdchk(ADDR_STATUS, 32'h46);
    wait_irq(200);
    rdchk(ADDR_STATUS, 32'hc6);
    cyc(140);
    wr(ADDR_STATUS, 32'h46);
    rdchk(ADDR_STATUS, 32'hc6);
    wr(ADDR_STATUS, 32'h86);
    cyc(3);
    check(timer_irq, 32'h0);
    wr(ADDR_STATUS, 32'ha6);
    rdchk(ADDR_STATUS, 32'ha6);
    wr(ADDR_STATUS, 32'h36);
    wr(ADDR_MOD_HI, 32'h0);
    wr(ADDR_STATUS, 32'h06);
    cyc(300);
    rdchk(ADDR_STATUS, 32'h06);
    wr(ADDR_MOD_LO, 32'h1);
    cyc(300);
    rdchk(ADDR_STATUS, 32'h86);
    wr(ADDR_MOD_HI, 32'hff);
    wr(ADDR_MOD_LO, 32'hff);
    for (int ps = 0; ps < 7; ps++) begin
      wr(ADDR_STATUS, 32'h30 | ps);
      rdchk(ADDR_CNT_LO, 32'h0);
      wr(ADDR_STATUS, ps);
      cyc(16 << ps);
      wr(ADDR_STATUS, 32'h20 | ps);
      xfer(1'b0, ADDR_CNT_HI, 32'h0);
      v = rd;
      xfer(1'b0, ADDR_CNT_LO, 32'h0);
      v = v * 256 + rd;
      k = ((16 << ps) + 4) >> ps;
      check(v >= k - 1 && v <= k + 1, 32'h1);
    end
    k = 1 + $urandom % 8;
    wr(ADDR_STATUS, 32'h37);
    wr(ADDR_STATUS, 32'h07);
    partner.pulses(k);
    cyc(10);
    wr(ADDR_STATUS, 32'h27);
    rdchk(ADDR_CNT_LO, k);
    wr(ADDR_STATUS, 32'h30);
    wr(ADDR_STATUS, 32'h00);
    xfer(1'b0, ADDR_CNT_HI, 32'h0);
    cyc(20);
    xfer(1'b0, ADDR_CNT_HI, 32'h0);
    xfer(1'b0, ADDR_CNT_LO, 32'h0);
    check(rd < 8, 32'h1);
    wr(8'h14, 32'h10);
    cyc(2);
    check({pin_oe[0], pin_out[0]}, 32'h0);
    wr(8'h14, 32'h00);
    cyc(2);
    check({pin_oe[0], pin_out[0]}, 32'h1);
    for (int e = 1; e < 4; e++) begin
      v = 40 + $urandom % 64;
      wr(ADDR_STATUS, 32'h30);
      wr(8'h18, 32'h0);
      wr(8'h1c, v);
      wr(8'h14, 32'h50 | e << 2);
      cyc(2);
      hi = pin_out[0];
      wr(ADDR_STATUS, 32'h0);
      wait_irq(300);
      check({pin_oe[0], pin_out[0]}, {1'b1, (e == 1) ? ~hi[0] : e[0]});
      rdchk(8'h14, 32'hd0 | e << 2);
      wr(8'h14, 32'h50 | e << 2);
      cyc(3);
      check(timer_irq, 32'h0);
    end
    wr(ADDR_STATUS, 32'h30);
    wr(8'h14, 32'h1f);
    cyc(2);
    check(pin_out[0], 32'h0);
    wr(ADDR_MOD_HI, 32'h0);
    wr(ADDR_MOD_LO, 32'h3f);
    wr(8'h1c, 32'h10);
    wr(8'h14, 32'h1a);
    wr(ADDR_STATUS, 32'h0);
    hi = 0;
    for (int c = 0; c < 256; c++) begin
      @(posedge hclk);
      hi += pin_out[0];
    end
    check(hi > 40 && hi < 120, 32'h1);
    wr(8'h20, 32'h38);
    rdchk(8'h20, 32'h18);
    check(pin_oe[1], 32'h1);
    wr(8'h14, 32'h28);
    cyc(2);
    check(pin_oe[1], 32'h0);
    wr(8'h14, 32'h0);
    for (int e = 1; e < 4; e++) begin
      wr(8'h20, 32'h40 | e << 2);
      xfer(1'b0, 8'h20, 32'h0);
      wr(8'h20, 32'h40 | e << 2);
      level_req[1] <= 1'b1;
      cyc(10);
      check(timer_irq, e[0]);
      xfer(1'b0, 8'h20, 32'h0);
      wr(8'h20, 32'h40 | e << 2);
      level_req[1] <= 1'b0;
      cyc(10);
      check(timer_irq, e[1]);
      xfer(1'b0, 8'h20, 32'h0);
      wr(8'h20, 32'h40 | e << 2);
    end
    wr(ADDR_STATUS, 32'h20);
    level_req[1] <= 1'b1;
    cyc(10);
    check(timer_irq, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
